// file: core/tsm_consts.svh
// constants for the timestamp modulo event generator
//
// Functional notes
// - The local counter advances on a 1 us tick and the synchronised counter on an 8 ns tick, both without stopping.
// - A clear command zeroes the active counter when sync mode is off, and only the local counter when sync mode is on.
// - The first event fires at the first period multiple after the start time, then again every period ticks until stopped.
// - The counter value of the first event is kept in a readable first-event-time value.
// - A clear after the start time but before the first event keeps the stored first-event time, which the restarted counter must reach.
// - A clear after events have begun restarts events from the first period multiple of the restarted counter.
// - A new period taken while running applies from the previous event onward.
// - The timestamp counter is readable by software as a 64-bit value.
// - A latch command copies the current counter into the readable snapshot.
// - Sync mode switches the time base to the synchronised counter, which user clears never touch.
`ifndef TSM_CONSTS_SVH
`define TSM_CONSTS_SVH

// timing, in ns, and the clock period
`define TSM_CLK_NS 4
`define TSM_LOC_TICK_NS 1000
`define TSM_SYN_TICK_NS 8

// widths
`define TSM_CNT_W 64
`define TSM_PER_W 32

// register byte offsets
`define TSM_REG_CTRL 12'h000
`define TSM_REG_CMD 12'h004
`define TSM_REG_START_LO 12'h008
`define TSM_REG_START_HI 12'h00C
`define TSM_REG_PERIOD 12'h010
`define TSM_REG_FIRST_LO 12'h014
`define TSM_REG_FIRST_HI 12'h018
`define TSM_REG_SNAP_LO 12'h01C
`define TSM_REG_SNAP_HI 12'h020
`define TSM_REG_STATUS 12'h024
`define TSM_REG_MASK 12'h028
`define TSM_REG_STATE 12'h02C

// field positions
`define TSM_CTRL_SYNC_BIT 0
`define TSM_CTRL_EN_BIT 1
`define TSM_CMD_CLEAR_BIT 0
`define TSM_CMD_LATCH_BIT 1
`define TSM_ST_EVENT_BIT 0
`define TSM_ST_FIRST_BIT 1
`define TSM_IRQ_W 2

// reset values
`define TSM_PERIOD_RST 32'h0000_0001
`define TSM_ZERO32 32'h0000_0000
`define TSM_ZERO64 64'h0000_0000_0000_0000
`define TSM_ONE64 64'h0000_0000_0000_0001

`endif

// file: core/tsm_pkg.sv
// types shared by the timestamp modulo event generator
package tsm_pkg;
    // modulo engine states
    typedef enum logic [1:0] {
        TSM_IDLE  = 2'b00,
        TSM_ARMED = 2'b01,
        TSM_FIRST = 2'b10,
        TSM_RUN   = 2'b11
    } tsm_state_e;
endpackage

// file: core/tsm_tick_div.sv
// tick divider: one-cycle enable pulse every DIV clocks
`timescale 1ns/1ps
module tsm_tick_div #(
    parameter int DIV = 250
) (
    input wire logic clk,     // system clock
    input wire logic arst_n,  // async reset, active low
    output logic tick         // one-cycle enable pulse
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt;

    // free-running count, pulse on the last step
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= '0;
            tick <= 1'b0;
        end else if (cnt == LAST) begin
            cnt <= '0;
            tick <= 1'b1;
        end else begin
            cnt <= cnt + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule

// file: core/tsm_top.sv
// timestamp counters, modulo event engine and ahb-lite register slave
//
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "tsm_consts.svh"
module tsm_top #(
    parameter int LOC_DIV = `TSM_LOC_TICK_NS / `TSM_CLK_NS,
    parameter int SYN_DIV = `TSM_SYN_TICK_NS / `TSM_CLK_NS
) (
    input wire logic clk,              // 250 MHz clock
    input wire logic arst_n,           // async reset, active low
    input wire logic hsel,             // slave select
    input wire logic [31:0] haddr,     // byte address
    input wire logic [1:0] htrans,     // transfer type
    input wire logic hwrite,           // write when high
    input wire logic [2:0] hsize,      // transfer size, word only
    input wire logic [31:0] hwdata,    // write data
    input wire logic hready,           // bus ready
    output logic hreadyout,            // slave ready
    output logic hresp,                // always okay
    output logic [31:0] hrdata,        // read data
    output logic modulo_event,         // one-cycle event pulse
    output logic irq                   // level interrupt
);
    import tsm_pkg::*;

    localparam int CW = `TSM_CNT_W;
    localparam int PW = `TSM_PER_W;

    // local and synchronised ticks
    logic loc_tick;
    logic syn_tick;

    tsm_tick_div #(.DIV(LOC_DIV)) u_loc_div (
        .clk(clk),
        .arst_n(arst_n),
        .tick(loc_tick)
    );

    tsm_tick_div #(.DIV(SYN_DIV)) u_syn_div (
        .clk(clk),
        .arst_n(arst_n),
        .tick(syn_tick)
    );

    // software-visible control state
    logic network_time_sync_mode;
    logic modulo_enable;
    logic [CW-1:0] modulo_start_time;
    logic [PW-1:0] modulo_period;
    logic [CW-1:0] modulo_first_event_time;
    logic [CW-1:0] time_counter_snapshot;
    logic [`TSM_IRQ_W-1:0] int_status;
    logic [`TSM_IRQ_W-1:0] int_mask;
    logic time_counter_clear_cmd;
    logic time_counter_latch_cmd;

    // counters and per-counter phase within the period
    logic [CW-1:0] loc_cnt;
    logic [CW-1:0] syn_cnt;
    logic [PW-1:0] loc_phase;
    logic [PW-1:0] syn_phase;

    // engine state
    tsm_state_e state;
    logic [PW-1:0] since_ev; // active ticks since the last event
    logic fire;
    logic fire_first;

    // bus data-phase bookkeeping
    logic wr_pend;
    logic [11:0] wr_addr;

    // period of zero acts as one
    logic [PW-1:0] eff_period;
    assign eff_period = (modulo_period == '0) ? PW'(1) : modulo_period;

    // selection of the active time base
    logic act_tick;
    logic [CW-1:0] act_cnt;
    logic [PW-1:0] act_phase;
    logic act_clear;
    assign act_tick = network_time_sync_mode ? syn_tick : loc_tick;
    assign act_cnt = network_time_sync_mode ? syn_cnt : loc_cnt;
    assign act_phase = network_time_sync_mode ? syn_phase : loc_phase;
    // a clear reaches the engine only when the local base is active
    assign act_clear = time_counter_clear_cmd & ~network_time_sync_mode;

    // local counter: 1 us tick, zeroed by every clear command
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            loc_cnt <= `TSM_ZERO64;
        end else if (time_counter_clear_cmd) begin
            loc_cnt <= `TSM_ZERO64;
        end else if (loc_tick) begin
            loc_cnt <= loc_cnt + `TSM_ONE64;
        end
    end

    // synchronised counter: 8 ns tick, never cleared by the user
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            syn_cnt <= `TSM_ZERO64;
        end else if (syn_tick) begin
            syn_cnt <= syn_cnt + `TSM_ONE64;
        end
    end

    // local phase, counter modulo period
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            loc_phase <= '0;
        end else if (time_counter_clear_cmd) begin
            loc_phase <= '0;
        end else if (loc_tick) begin
            if (loc_phase >= eff_period - PW'(1)) begin
                loc_phase <= '0;
            end else begin
                loc_phase <= loc_phase + PW'(1);
            end
        end
    end

    // synchronised phase, counter modulo period
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            syn_phase <= '0;
        end else if (syn_tick) begin
            if (syn_phase >= eff_period - PW'(1)) begin
                syn_phase <= '0;
            end else begin
                syn_phase <= syn_phase + PW'(1);
            end
        end
    end

    // modulo event engine
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= TSM_IDLE;
            since_ev <= '0;
            fire <= 1'b0;
            fire_first <= 1'b0;
            modulo_first_event_time <= `TSM_ZERO64;
        end else begin
            fire <= 1'b0;
            fire_first <= 1'b0;
            if (!modulo_enable) begin
                state <= TSM_IDLE;
            end else begin
                case (state)
                    TSM_IDLE: begin
                        state <= TSM_ARMED;
                    end
                    TSM_ARMED: begin
                        // start reached: next boundary after it
                        if (!act_clear && act_cnt >= modulo_start_time) begin
                            modulo_first_event_time <= act_cnt
                                + CW'(eff_period - act_phase);
                            state <= TSM_FIRST;
                        end
                    end
                    TSM_FIRST: begin
                        // stored time survives a clear
                        if (!act_clear &&
                            act_cnt == modulo_first_event_time) begin
                            fire <= 1'b1;
                            fire_first <= 1'b1;
                            since_ev <= '0;
                            state <= TSM_RUN;
                        end
                    end
                    TSM_RUN: begin
                        // count up from the last event, so a new period
                        // applies at once and each event lags its tick
                        // by one clock, like the first one
                        if (act_clear) begin
                            since_ev <= '0;
                        end else if (since_ev >= eff_period) begin
                            fire <= 1'b1;
                            since_ev <= act_tick ? PW'(1) : '0;
                        end else if (act_tick) begin
                            since_ev <= since_ev + PW'(1);
                        end
                    end
                    default: begin
                        state <= TSM_IDLE;
                    end
                endcase
            end
        end
    end

    // event pulse output
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            modulo_event <= 1'b0;
        end else begin
            modulo_event <= fire;
        end
    end

    // snapshot of the active counter on a latch command
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            time_counter_snapshot <= `TSM_ZERO64;
        end else if (time_counter_latch_cmd) begin
            time_counter_snapshot <= act_cnt;
        end
    end

    // bus decode
    logic addr_ok;
    logic rd_req;
    logic wr_req;
    logic wr_now;
    assign addr_ok = hsel & htrans[1] & hready;
    assign rd_req = addr_ok & ~hwrite;
    assign wr_req = addr_ok & hwrite;
    assign wr_now = wr_pend;

    // capture write address for the data phase
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_pend <= 1'b0;
            wr_addr <= 12'h000;
        end else begin
            wr_pend <= wr_req;
            if (wr_req) begin
                wr_addr <= haddr[11:0];
            end
        end
    end

    // always ready, always okay
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // control register writes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            network_time_sync_mode <= 1'b0;
            modulo_enable <= 1'b0;
            modulo_start_time <= `TSM_ZERO64;
            modulo_period <= `TSM_PERIOD_RST;
            int_mask <= '0;
        end else if (wr_now) begin
            case (wr_addr)
                `TSM_REG_CTRL: begin
                    network_time_sync_mode <= hwdata[`TSM_CTRL_SYNC_BIT];
                    modulo_enable <= hwdata[`TSM_CTRL_EN_BIT];
                end
                `TSM_REG_START_LO: begin
                    modulo_start_time[31:0] <= hwdata;
                end
                `TSM_REG_START_HI: begin
                    modulo_start_time[63:32] <= hwdata;
                end
                `TSM_REG_PERIOD: begin
                    modulo_period <= hwdata[PW-1:0];
                end
                `TSM_REG_MASK: begin
                    int_mask <= hwdata[`TSM_IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // command pulses, one cycle each
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            time_counter_clear_cmd <= 1'b0;
            time_counter_latch_cmd <= 1'b0;
        end else begin
            time_counter_clear_cmd <= wr_now && wr_addr == `TSM_REG_CMD
                && hwdata[`TSM_CMD_CLEAR_BIT];
            time_counter_latch_cmd <= wr_now && wr_addr == `TSM_REG_CMD
                && hwdata[`TSM_CMD_LATCH_BIT];
        end
    end

    // sticky status, write one to clear, set wins
    logic [`TSM_IRQ_W-1:0] st_set;
    logic [`TSM_IRQ_W-1:0] st_clr;
    assign st_set = {fire_first, fire};
    assign st_clr = (wr_now && wr_addr == `TSM_REG_STATUS)
        ? hwdata[`TSM_IRQ_W-1:0] : '0;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            int_status <= '0;
        end else begin
            int_status <= (int_status & ~st_clr) | st_set;
        end
    end

    // interrupt level
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_status & int_mask);
        end
    end

    // read mux, registered at the address phase
    logic [31:0] rd_val;
    always_comb begin
        rd_val = `TSM_ZERO32;
        case (haddr[11:0])
            `TSM_REG_CTRL: begin
                rd_val[`TSM_CTRL_SYNC_BIT] = network_time_sync_mode;
                rd_val[`TSM_CTRL_EN_BIT] = modulo_enable;
            end
            `TSM_REG_START_LO: rd_val = modulo_start_time[31:0];
            `TSM_REG_START_HI: rd_val = modulo_start_time[63:32];
            `TSM_REG_PERIOD: rd_val = 32'(modulo_period);
            `TSM_REG_FIRST_LO: rd_val = modulo_first_event_time[31:0];
            `TSM_REG_FIRST_HI: rd_val = modulo_first_event_time[63:32];
            `TSM_REG_SNAP_LO: rd_val = time_counter_snapshot[31:0];
            `TSM_REG_SNAP_HI: rd_val = time_counter_snapshot[63:32];
            `TSM_REG_STATUS: rd_val[`TSM_IRQ_W-1:0] = int_status;
            `TSM_REG_MASK: rd_val[`TSM_IRQ_W-1:0] = int_mask;
            `TSM_REG_STATE: rd_val[1:0] = state;
            default: rd_val = `TSM_ZERO32;
        endcase
        if (haddr[31:12] != 20'h0_0000) begin
            rd_val = `TSM_ZERO32;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hrdata <= `TSM_ZERO32;
        end else if (rd_req) begin
            hrdata <= rd_val;
        end
    end
endmodule

// file: tb/tsm_top_props.sv
// port checker for the timestamp modulo event generator
`timescale 1ns/1ps
`include "tsm_consts.svh"
module tsm_top_props #(
    parameter int LOC_DIV = 250,
    parameter int SYN_DIV = 2
) (
    input wire logic clk, // clock
    input wire logic arst_n, // reset, active low
    input wire logic hsel, // select
    input wire logic [31:0] haddr, // address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write flag
    input wire logic [2:0] hsize, // size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    input wire logic hreadyout, // slave ready
    input wire logic hresp, // response
    input wire logic [31:0] hrdata, // read data
    input wire logic modulo_event, // event pulse
    input wire logic irq // interrupt
);
    logic wv; // write data phase
    logic [11:0] wa; // its address
    logic en_sh; // enable shadow
    logic mask0; // event mask shadow
    logic [31:0] per_sh; // period shadow
    logic mwr; // mask write in data phase
    // shadows of written controls
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wv <= 1'b0;
            wa <= 12'h000;
            en_sh <= 1'b0;
            mask0 <= 1'b0;
            per_sh <= `TSM_PERIOD_RST;
        end else begin
            wv <= hsel && htrans[1] && hready && hwrite;
            wa <= haddr[11:0];
            if (wv && wa == `TSM_REG_CTRL)
                en_sh <= hwdata[`TSM_CTRL_EN_BIT];
            if (mwr)
                mask0 <= hwdata[`TSM_ST_EVENT_BIT];
            if (wv && wa == `TSM_REG_PERIOD)
                per_sh <= hwdata;
        end
    end
    assign mwr = wv && wa == `TSM_REG_MASK;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // read address phase at one offset
    sequence rd_at(logic [11:0] a);
        hsel && htrans[1] && hready && !hwrite && haddr == {20'h0_0000, a};
    endsequence
    a_event_pulse: assert property (modulo_event |=> !modulo_event)
        else $error("event pulse longer than one cycle");
    a_resp_okay: assert property (hresp == 1'b0 && hreadyout)
        else $error("bus answer not ready and okay");
    a_event_enabled: assert property (modulo_event |-> en_sh ||
        $past(en_sh) || $past(en_sh, 2) || $past(en_sh, 3))
        else $error("event while engine disabled");
    a_cmd_reads_zero: assert property (rd_at(`TSM_REG_CMD) |=> hrdata == 0)
        else $error("command register read not zero");
    a_unmapped_zero: assert property (rd_at(12'h100) |=> hrdata == 0)
        else $error("unmapped read not zero");
    a_period_back: assert property (rd_at(`TSM_REG_PERIOD) |=>
        hrdata == $past(per_sh))
        else $error("period readback wrong");
    a_irq_cause: assert property ($rose(irq) |->
        $past(modulo_event) || $past(mwr, 2))
        else $error("irq rose without cause");
    a_irq_follows: assert property (modulo_event && mask0 |=> irq)
        else $error("irq missing after unmasked event");
endmodule

// file: tb/tsm_trig_sink.sv
// trigger consumer model counting events and their spacing
`timescale 1ns/1ps
module tsm_trig_sink (
    input wire logic clk, // clock
    input wire logic arst_n, // reset, active low
    input wire logic trig, // event pulse
    output int n_events, // events seen
    output int last_gap // clocks between last two events
);
    int since; // clocks since last event
    // count pulses and measure spacing
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            n_events <= 0;
            last_gap <= 0;
            since <= 0;
        end else begin
            since <= trig ? 0 : since + 1;
            if (trig) begin
                n_events <= n_events + 1;
                last_gap <= since + 1;
            end
        end
    end
endmodule

// file: tb/timestamp_modulo_event_gen_tb_top.sv
// testbench for the timestamp modulo event generator
`timescale 1ns/1ps
`include "tsm_consts.svh"
module timestamp_modulo_event_gen_tb_top;
    typedef struct packed {
        logic w;
        logic [11:0] a;
        logic [31:0] v;
    } tsm_row_s;
    localparam int LD = 5; // local tick in clocks
    localparam int SD = `TSM_SYN_TICK_NS / `TSM_CLK_NS; // sync tick in clocks
    logic clk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
    logic [31:0] hrdata, rd, s1;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic hready, hreadyout, hresp, ev, irq;
    int miscompares = 0, cmp_count = 0, ev_n, gap, c;
    tsm_row_s rows [16] = '{
        '{1'b0, `TSM_REG_CTRL, 32'h0000_0000},
        '{1'b0, `TSM_REG_CMD, 32'h0000_0000},
        '{1'b0, `TSM_REG_PERIOD, 32'h0000_0001},
        '{1'b0, `TSM_REG_FIRST_LO, 32'h0000_0000},
        '{1'b0, `TSM_REG_SNAP_HI, 32'h0000_0000},
        '{1'b0, `TSM_REG_STATUS, 32'h0000_0000},
        '{1'b0, `TSM_REG_MASK, 32'h0000_0000},
        '{1'b0, `TSM_REG_STATE, 32'h0000_0000},
        '{1'b1, 12'h100, 32'h0000_0005},
        '{1'b0, 12'h100, 32'h0000_0000},
        '{1'b1, `TSM_REG_PERIOD, 32'h0000_000A},
        '{1'b0, `TSM_REG_PERIOD, 32'h0000_000A},
        '{1'b1, `TSM_REG_START_LO, 32'h0000_0014},
        '{1'b1, `TSM_REG_MASK, 32'h0000_0003},
        '{1'b1, `TSM_REG_CMD, 32'h0000_0001},
        '{1'b1, `TSM_REG_CTRL, 32'h0000_0002}};
    tsm_row_s isteps [3] = '{'{1'b0, `TSM_REG_MASK, 32'h0000_0000},
        '{1'b1, `TSM_REG_MASK, 32'h0000_0003},
        '{1'b0, `TSM_REG_STATUS, 32'h0000_0003}};
    // clock and bus ready
    always #2 clk = ~clk;
    assign hready = hreadyout;
    tsm_top #(.LOC_DIV(LD)) tsm_top_i (.clk(clk), .arst_n(arst_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .modulo_event(ev), .irq(irq));
    tsm_trig_sink tsm_trig_sink_i (.clk(clk), .arst_n(arst_n), .trig(ev),
        .n_events(ev_n), .last_gap(gap));
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic rng(input string nm, input logic [31:0] lo, hi, g);
        cmp_count++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            miscompares++;
            $display("CHECK FAILED %s expected %0h..%0h seen %0h", nm, lo, hi, g);
        end
    endtask
    task automatic edge_rdy;
        int n;
        n = 0;
        @(posedge clk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 100) begin
                miscompares++;
                print_verdict();
            end
            @(posedge clk);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {20'h0_0000, a};
        htrans <= 2'b10;
        hwrite <= w;
        edge_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        edge_rdy();
        rd = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic snap;
        wr(`TSM_REG_CMD, 32'h0000_0002);
        @(posedge clk); // latch lands one edge after the write
        bus(1'b0, `TSM_REG_SNAP_LO, 32'h0000_0000);
    endtask
    task automatic wait_ev(input int n);
        c = 0;
        while (ev_n < n) begin
            @(posedge clk);
            c++;
            if (c > 3000) begin
                miscompares++;
                print_verdict();
            end
        end
    endtask
    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        foreach (rows[i]) begin
            bus(rows[i].w, rows[i].a, rows[i].v);
            if (!rows[i].w)
                chk("register", rows[i].v, rd);
        end
        $display("test registers done");
        wait_ev(1);
        bus(1'b0, `TSM_REG_FIRST_LO, 32'h0000_0000);
        chk("first time", 32'h0000_001E, rd);
        wait_ev(2);
        chk("gap", 32'(10 * LD), 32'(gap));
        wr(`TSM_REG_PERIOD, 32'h0000_0014);
        bus(1'b0, `TSM_REG_STATUS, 32'h0000_0000);
        chk("status", 32'h0000_0003, rd);
        foreach (isteps[i]) begin
            wr(isteps[i].a, isteps[i].v);
            repeat (2) @(posedge clk);
            chk("irq", {31'h0000_0000, isteps[i].w}, {31'h0000_0000, irq});
        end
        $display("test first event done");
        wait_ev(3);
        chk("new gap", 32'(20 * LD), 32'(gap));
        wait_ev(4);
        chk("new gap", 32'(20 * LD), 32'(gap));
        repeat (10) @(posedge clk);
        wr(`TSM_REG_CMD, 32'h0000_0001);
        wait_ev(5);
        rng("restart", 32'(20 * LD - 10), 32'(20 * LD + 12), 32'(c));
        $display("test period change done");
        wr(`TSM_REG_CTRL, 32'h0000_0001);
        snap();
        s1 = rd;
        wr(`TSM_REG_CMD, 32'h0000_0001);
        snap();
        rng("sync clear", s1 + 32'h0000_0003, s1 + 32'h0000_0004, rd);
        wr(`TSM_REG_CTRL, 32'h0000_0000);
        snap();
        s1 = rd;
        repeat (93) @(posedge clk);
        bus(1'b0, `TSM_REG_SNAP_LO, 32'h0000_0000);
        chk("snapshot held", s1, rd);
        snap();
        chk("local rate", s1 + 32'h0000_0014, rd);
        wr(`TSM_REG_CMD, 32'h0000_0001);
        snap();
        rng("local clear", 32'h0000_0000, 32'h0000_0001, rd);
        $display("test counters done");
        wr(`TSM_REG_CMD, 32'h0000_0001);
        wr(`TSM_REG_PERIOD, 32'h0000_000A);
        wr(`TSM_REG_CTRL, 32'h0000_0002);
        repeat (120) @(posedge clk);
        wr(`TSM_REG_CMD, 32'h0000_0001);
        wait_ev(6);
        rng("held first", 32'(30 * LD - 12), 32'(30 * LD + 12), 32'(c));
        bus(1'b0, `TSM_REG_FIRST_LO, 32'h0000_0000);
        chk("first kept", 32'h0000_001E, rd);
        $display("test early clear done");
        wr(`TSM_REG_CTRL, 32'h0000_0001);
        wr(`TSM_REG_CTRL, 32'h0000_0003);
        wait_ev(7);
        wait_ev(8);
        chk("sync gap", 32'(10 * SD), 32'(gap));
        $display("test sync events done");
        arst_n <= 1'b0;
        @(posedge clk);
        chk("irq in reset", 32'h0000_0000, {31'h0000_0000, irq});
        arst_n <= 1'b1;
        @(posedge clk);
        bus(1'b0, `TSM_REG_CTRL, 32'h0000_0000);
        chk("ctrl after reset", 32'h0000_0000, rd);
        $display("test second reset done");
        print_verdict();
    end
endmodule
bind tsm_top tsm_top_props #(.LOC_DIV(LOC_DIV), .SYN_DIV(SYN_DIV))
    tsm_top_props_i (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .modulo_event(modulo_event), .irq(irq));
